// ==== src/annp_pkg.sv ====
/*
 * Shared constants of the next-page transmit register bank: register
 * offsets, field positions, reset values and the crossover mode encoding.
 * Assumes a 5-bit management register address and 16-bit register words.
 */
package annp_pkg;

    // ==========================================================
    // register map
    // ==========================================================
    localparam int ANNP_ADDR_W = 5;
    localparam int ANNP_DATA_W = 16;
    localparam logic [4:0] ANNP_OFS_NEXT_PAGE_TX = 5'h07;
    localparam logic [4:0] ANNP_OFS_PHY_STATUS = 5'h10;

    // ==========================================================
    // next_page_transmit fields
    // ==========================================================
    localparam int ANNP_BIT_MORE_PAGES = 15;
    localparam int ANNP_BIT_NP_RSVD = 14;
    localparam int ANNP_BIT_MSG_PAGE = 13;
    localparam int ANNP_BIT_COMPLY_ACK = 12;
    localparam int ANNP_BIT_TX_TOGGLE = 11;
    localparam int ANNP_CODE_MSB = 10;
    localparam int ANNP_CODE_W = 11;

    localparam logic ANNP_RST_MORE_PAGES = 1'h0;
    localparam logic ANNP_RST_MSG_PAGE = 1'h1;
    localparam logic ANNP_RST_COMPLY_ACK = 1'h0;
    localparam logic ANNP_RST_TX_TOGGLE = 1'h0;
    // null message page
    localparam logic [10:0] ANNP_RST_CODE = 11'h001;

    // ==========================================================
    // phy_status_summary fields
    // ==========================================================
    localparam int ANNP_BIT_ST_RSVD = 15;
    localparam int ANNP_BIT_XOVER_STATE = 14;
    localparam int ANNP_ST_LOW_W = 14;
    localparam logic ANNP_RST_XOVER_STATE = 1'h0;

    // ==========================================================
    // crossover pair assignment
    // ==========================================================
    typedef enum logic {
        ANNP_PAIRS_NORMAL,
        ANNP_PAIRS_SWAPPED
    } annp_pairs_t;

endpackage : annp_pkg

// ==== src/annp_xover_status.sv ====
/*
 * Crossover state indicator: derives the reported pair assignment from the
 * crossover enable and force settings and the crossover algorithm's choice.
 * Assumes all inputs come from logic on ref_clk.
 */
`timescale 1ns/1ps
module annp_xover_status
    import annp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic crossover_enable,
    input wire logic crossover_force,
    input wire logic algo_swapped,
    output logic crossover_state
);

    // ==========================================================
    // state selection
    // ==========================================================
    annp_pairs_t pairs;
    annp_pairs_t next_pairs;

    always_comb begin
        // forcing wins; with crossover disabled the pairs stay normal
        if (crossover_force) begin
            next_pairs = ANNP_PAIRS_SWAPPED;
        end else if (crossover_enable) begin
            // follows the algorithm every cycle as it alternates
            next_pairs = algo_swapped ? ANNP_PAIRS_SWAPPED : ANNP_PAIRS_NORMAL;
        end else begin
            next_pairs = ANNP_PAIRS_NORMAL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pairs <= ANNP_PAIRS_NORMAL;
        end else if (clk_en) begin
            pairs <= next_pairs;
        end
    end

    // 1 means receive on the transmit pair and transmit on the receive pair
    assign crossover_state = (pairs == ANNP_PAIRS_SWAPPED);

endmodule : annp_xover_status

// ==== src/annp_next_page_regs.sv ====
/*
 * Next-page transmit register and top of the phy status summary register,
 * as seen on the management register port, plus the link code word handed
 * to the auto-negotiation arbitration logic.
 * Assumes the register port, arbitration and crossover logic all run on
 * ref_clk; strobes are one-cycle pulses qualified by clk_en.
 * clk_en low freezes every register here, the read answer included.
 * The crossover indicator itself is built in annp_xover_status.
 */
// Notes on behaviour
// - bit 15 asks for another next page; read-write, resets to 0.
// - bit 14 of the next-page register ignores writes and reads 0.
// - bit 13 selects message page (1) or unformatted page; resets to 1.
// - bit 12 says local device will comply with message; read-write, resets 0.
// - bit 11 is read-only, opposite of toggle in previously exchanged code word.
// - bits 10:0 are the read-write code field, reset to null page 001.
// - status bit 15 ignores writes and reads 0.
// - status bit 14 shows crossover state from enable and force settings.
// - with crossover enabled, not forced, the bit tracks the algorithm live.
// - status bit 14 reads 1 for swapped pairs, 0 for normal pairs.
`timescale 1ns/1ps
module annp_next_page_regs
    import annp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic base_page_sent,
    input wire logic base_page_toggle,
    input wire logic next_page_sent,
    output logic [15:0] tx_link_code_word,
    output logic next_page_loaded,
    input wire logic crossover_enable,
    input wire logic crossover_force,
    input wire logic algo_swapped,
    input wire logic [13:0] status_low_bits,
    output logic crossover_state
);

    // ==========================================================
    // helpers
    // ==========================================================
    // assembles the 16-bit next-page word; bit 14 is always 0
    // the toggle comes in as an argument so reads and sends share one layout
    function automatic logic [15:0] annp_pack(input logic more, input logic msg,
                                              input logic ack, input logic tog,
                                              input logic [10:0] code);
        logic [15:0] w;
        w = 16'h0000;
        w[ANNP_BIT_MORE_PAGES] = more;
        w[ANNP_BIT_NP_RSVD] = 1'b0;
        w[ANNP_BIT_MSG_PAGE] = msg;
        w[ANNP_BIT_COMPLY_ACK] = ack;
        w[ANNP_BIT_TX_TOGGLE] = tog;
        w[ANNP_CODE_MSB:0] = code;
        return w;
    endfunction : annp_pack

    // one compare per register keeps the write and read decodes in step
    function automatic logic annp_hit(input logic [4:0] addr, input logic [4:0] ofs);
        return addr == ofs;
    endfunction : annp_hit

    // ==========================================================
    // next-page register state
    // ==========================================================
    logic more_pages_wanted;
    logic message_page_flag;
    logic comply_ack;
    logic tx_toggle_flag;
    logic [10:0] page_code;
    // set by a write, cleared by a send; a write in the same cycle wins
    logic page_pending;
    // last word handed to the arbitration logic; holds between sends
    logic [15:0] sent_word;

    logic next_more_pages_wanted;
    logic next_message_page_flag;
    logic next_comply_ack;
    logic next_tx_toggle_flag;
    logic [10:0] next_page_code;
    logic next_page_pending;
    logic [15:0] next_sent_word;

    logic wr_np;
    logic [15:0] np_word;

    // ==========================================================
    // address decode
    // ==========================================================
    // a write that hits the status offset decodes to nothing and is dropped
    logic rd_np;
    logic rd_st;

    assign wr_np = reg_wr && annp_hit(reg_addr, ANNP_OFS_NEXT_PAGE_TX);
    assign rd_np = annp_hit(reg_addr, ANNP_OFS_NEXT_PAGE_TX);
    assign rd_st = annp_hit(reg_addr, ANNP_OFS_PHY_STATUS);
    assign np_word = annp_pack(more_pages_wanted, message_page_flag, comply_ack,
                               tx_toggle_flag, page_code);

    always_comb begin
        // hold everything unless a write or a send says otherwise
        next_more_pages_wanted = more_pages_wanted;
        next_message_page_flag = message_page_flag;
        next_comply_ack = comply_ack;
        next_tx_toggle_flag = tx_toggle_flag;
        next_page_code = page_code;
        next_page_pending = page_pending;
        next_sent_word = sent_word;

        if (wr_np) begin
            // bit 14 and the toggle bit are not taken from the write
            next_more_pages_wanted = reg_wdata[ANNP_BIT_MORE_PAGES];
            next_message_page_flag = reg_wdata[ANNP_BIT_MSG_PAGE];
            next_comply_ack = reg_wdata[ANNP_BIT_COMPLY_ACK];
            next_page_code = reg_wdata[ANNP_CODE_MSB:0];
        end

        if (base_page_sent) begin
            // first next page must carry the opposite of the base page toggle
            next_tx_toggle_flag = ~base_page_toggle;
        end else if (next_page_sent) begin
            // word is taken from the fields as they stand before this cycle's write
            next_sent_word = np_word;
            next_tx_toggle_flag = ~tx_toggle_flag;
        end

        // a new page written in the same cycle as a send stays pending
        if (wr_np) begin
            next_page_pending = 1'b1;
        end else if (next_page_sent) begin
            next_page_pending = 1'b0;
        end
    end

    // reset wins over the enable; every field holds while clk_en is low
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            more_pages_wanted <= ANNP_RST_MORE_PAGES;
            message_page_flag <= ANNP_RST_MSG_PAGE;
            comply_ack <= ANNP_RST_COMPLY_ACK;
            // toggle restarts at 0; the first base page sets it properly
            tx_toggle_flag <= ANNP_RST_TX_TOGGLE;
            page_code <= ANNP_RST_CODE;
            page_pending <= 1'b0;
            sent_word <= 16'h0000;
        end else if (clk_en) begin
            more_pages_wanted <= next_more_pages_wanted;
            message_page_flag <= next_message_page_flag;
            comply_ack <= next_comply_ack;
            tx_toggle_flag <= next_tx_toggle_flag;
            page_code <= next_page_code;
            page_pending <= next_page_pending;
            sent_word <= next_sent_word;
        end
    end

    // both outputs are plain register copies, so they never glitch
    assign tx_link_code_word = sent_word;
    assign next_page_loaded = page_pending;

    // ==========================================================
    // crossover status
    // ==========================================================
    // live in the indicator; this bank only reports it
    annp_xover_status u_xover (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .crossover_enable(crossover_enable),
        .crossover_force(crossover_force),
        .algo_swapped(algo_swapped),
        .crossover_state(crossover_state)
    );

    // ==========================================================
    // read path
    // ==========================================================
    // only bits 15 and 14 belong to this bank; 13:0 pass through untouched
    logic [15:0] status_word;
    logic [15:0] next_reg_rdata;
    logic next_reg_rvalid;

    always_comb begin
        status_word = 16'h0000;
        status_word[ANNP_BIT_ST_RSVD] = 1'b0;
        status_word[ANNP_BIT_XOVER_STATE] = crossover_state;
        status_word[ANNP_ST_LOW_W-1:0] = status_low_bits;
    end

    // rdata holds between reads so a slow reader can still pick it up
    always_comb begin
        next_reg_rdata = reg_rdata;
        next_reg_rvalid = 1'b0;
        if (reg_rd) begin
            next_reg_rvalid = 1'b1;
            if (rd_np) begin
                next_reg_rdata = np_word;
            end else if (rd_st) begin
                next_reg_rdata = status_word;
            end else begin
                // unmapped offsets answer with zero rather than stale data
                next_reg_rdata = 16'h0000;
            end
        end
    end

    // clk_en low also holds rvalid, so a pulse caught by a freeze stands longer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

endmodule : annp_next_page_regs

// ==== test/annp_chk.sv ====
/* port checker of the next-page register bank.
   assumes a bind onto annp_next_page_regs, all on ref_clk */
`timescale 1ns/1ps
module annp_chk
    import annp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic base_page_sent,
    input wire logic base_page_toggle,
    input wire logic next_page_sent,
    input wire logic [15:0] tx_link_code_word,
    input wire logic next_page_loaded,
    input wire logic crossover_enable,
    input wire logic crossover_force,
    input wire logic algo_swapped,
    input wire logic crossover_state
);
    // ==========================================================
    // properties
    // ==========================================================
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_base;
        clk_en && base_page_sent;
    endsequence
    sequence s_next;
        clk_en && next_page_sent && !base_page_sent;
    endsequence
    sequence s_rd(a);
        clk_en && reg_rd && reg_addr == a;
    endsequence
    property p_rd;
        clk_en && reg_rd |=> reg_rvalid;
    endproperty
    property p_rsvd14;
        s_rd(ANNP_OFS_NEXT_PAGE_TX) |=> !reg_rdata[14];
    endproperty
    property p_st15;
        s_rd(ANNP_OFS_PHY_STATUS) |=> !reg_rdata[15];
    endproperty
    property p_st14;
        s_rd(ANNP_OFS_PHY_STATUS) |=> reg_rdata[14] == $past(crossover_state);
    endproperty
    property p_force;
        clk_en && crossover_force |=> crossover_state;
    endproperty
    property p_algo;
        clk_en && crossover_enable && !crossover_force |=> crossover_state == $past(algo_swapped);
    endproperty
    property p_off;
        clk_en && !crossover_enable && !crossover_force |=> !crossover_state;
    endproperty
    property p_sent;
        s_next ##0 !(reg_wr && reg_addr == ANNP_OFS_NEXT_PAGE_TX) |=>
            !next_page_loaded && !tx_link_code_word[14];
    endproperty
    property p_pend;
        clk_en && reg_wr && reg_addr == ANNP_OFS_NEXT_PAGE_TX |=> next_page_loaded;
    endproperty
    property p_tog;
        s_base ##1 s_next |=> tx_link_code_word[11] == !$past(base_page_toggle, 2);
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    a_rsvd14: assert property (p_rsvd14) else $error("bit 14 set");
    a_st15: assert property (p_st15) else $error("status 15 set");
    a_st14: assert property (p_st14) else $error("status 14 off");
    a_force: assert property (p_force) else $error("force ignored");
    a_algo: assert property (p_algo) else $error("algo not tracked");
    a_off: assert property (p_off) else $error("swapped when off");
    a_sent: assert property (p_sent) else $error("sent word wrong");
    a_tog: assert property (p_tog) else $error("toggle wrong");
    a_pend: assert property (p_pend) else $error("write not pending");
endmodule : annp_chk

// ==== test/annp_arb_model.sv ====
/* arbitration side model: pulses base and next page strobes.
   assumes the bench calls its tasks after a clock edge */
`timescale 1ns/1ps
module annp_arb_model (
    input wire logic ref_clk,
    output logic base_page_sent,
    output logic base_page_toggle,
    output logic next_page_sent
);
    initial begin
        base_page_sent = 1'h0;
        base_page_toggle = 1'h0;
        next_page_sent = 1'h0;
    end
    task automatic send_base(input logic t);
        @(posedge ref_clk);
        #1 base_page_sent = 1'h1;
        base_page_toggle = t;
        @(posedge ref_clk);
        #1 base_page_sent = 1'h0;
        // released toggle shows the inverse, not a stale copy
        base_page_toggle = ~t;
    endtask : send_base
    // called after or with a page write, whatever that page's more-pages bit holds
    task automatic send_next();
        @(posedge ref_clk);
        #1 next_page_sent = 1'h1;
        @(posedge ref_clk);
        #1 next_page_sent = 1'h0;
    endtask : send_next
    // base page straight into a next page with no idle cycle between
    task automatic send_base_next(input logic t);
        @(posedge ref_clk);
        #1 base_page_sent = 1'h1;
        base_page_toggle = t;
        @(posedge ref_clk);
        #1 base_page_sent = 1'h0;
        base_page_toggle = ~t;
        next_page_sent = 1'h1;
        @(posedge ref_clk);
        #1 next_page_sent = 1'h0;
    endtask : send_base_next
endmodule : annp_arb_model

// ==== test/annp_next_page_regs_bench.sv ====
/* self-checking bench of annp_next_page_regs.
   assumes annp_pkg, the arbitration model and the checker are compiled */
`timescale 1ns/1ps
module annp_next_page_regs_bench;
    import annp_pkg::*;
    logic ref_clk, sys_rst, clk_en, reg_wr, reg_rd, reg_rvalid;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, tx_link_code_word, shadow, w;
    logic base_page_sent, base_page_toggle, next_page_sent, next_page_loaded;
    logic crossover_enable, crossover_force, algo_swapped, crossover_state, tog;
    logic [13:0] status_low_bits;
    int error_cnt, comparisons;
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    annp_arb_model annp_arb_model_i (
        .ref_clk(ref_clk),
        .base_page_sent(base_page_sent),
        .base_page_toggle(base_page_toggle),
        .next_page_sent(next_page_sent)
    );
    annp_next_page_regs annp_next_page_regs_i (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .base_page_sent(base_page_sent),
        .base_page_toggle(base_page_toggle),
        .next_page_sent(next_page_sent),
        .tx_link_code_word(tx_link_code_word),
        .next_page_loaded(next_page_loaded),
        .crossover_enable(crossover_enable),
        .crossover_force(crossover_force),
        .algo_swapped(algo_swapped),
        .status_low_bits(status_low_bits),
        .crossover_state(crossover_state)
    );
    function automatic logic [15:0] exp_np();
        return {shadow[15], 1'h0, shadow[13:12], tog, shadow[10:0]};
    endfunction : exp_np
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(posedge ref_clk);
        #1 reg_wr = 1'h0;
        if (a == ANNP_OFS_NEXT_PAGE_TX) shadow = d;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        #1 reg_addr = a;
        reg_rd = 1'h1;
        @(posedge ref_clk);
        #1 reg_rd = 1'h0;
        check("rvalid", 16'h0001, {15'h0000, reg_rvalid});
        check("rdata", e, reg_rdata);
    endtask : rd
    task automatic stop_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        {clk_en, sys_rst, reg_wr, reg_rd, tog} = 5'h18;
        {reg_addr, reg_wdata, status_low_bits} = '0;
        {crossover_enable, crossover_force, algo_swapped} = 3'h0;
        error_cnt = 0;
        comparisons = 0;
        shadow = 16'h2001;
        void'($urandom(6404));
        repeat (8) @(posedge ref_clk);
        #1 sys_rst = 1'h0;
        rd(ANNP_OFS_NEXT_PAGE_TX, 16'h2001);
        status_low_bits = 14'($urandom);
        wr(ANNP_OFS_PHY_STATUS, 16'hffff);
        rd(ANNP_OFS_PHY_STATUS, {2'h0, status_low_bits});
        rd(5'h1f, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            wr(ANNP_OFS_NEXT_PAGE_TX, w);
            rd(ANNP_OFS_NEXT_PAGE_TX, exp_np());
        end
        // a write while clk_en is low must not land
        w = shadow;
        clk_en = 1'h0;
        wr(ANNP_OFS_NEXT_PAGE_TX, ~shadow);
        shadow = w;
        clk_en = 1'h1;
        rd(ANNP_OFS_NEXT_PAGE_TX, exp_np());
        for (int t = 0; t < 2; t++) begin
            annp_arb_model_i.send_base(t[0]);
            tog = ~t[0];
            rd(ANNP_OFS_NEXT_PAGE_TX, exp_np());
            for (int k = 0; k < 3; k++) begin
                wr(ANNP_OFS_NEXT_PAGE_TX, 16'($urandom));
                check("pending", 16'h0001, {15'h0000, next_page_loaded});
                w = exp_np();
                annp_arb_model_i.send_next();
                tog = ~tog;
                check("sent word", w, tx_link_code_word);
                check("loaded", 16'h0000, {15'h0000, next_page_loaded});
                rd(ANNP_OFS_NEXT_PAGE_TX, exp_np());
            end
            // base page straight into a next page
            wr(ANNP_OFS_NEXT_PAGE_TX, 16'($urandom));
            tog = ~t[0];
            w = exp_np();
            annp_arb_model_i.send_base_next(t[0]);
            check("chained word", w, tx_link_code_word);
            tog = t[0];
            // write and send in one cycle: old contents go out, pending stays set
            w = exp_np();
            fork
                wr(ANNP_OFS_NEXT_PAGE_TX, 16'($urandom));
                annp_arb_model_i.send_next();
            join
            tog = ~tog;
            check("racing word", w, tx_link_code_word);
            check("racing pending", 16'h0001, {15'h0000, next_page_loaded});
            rd(ANNP_OFS_NEXT_PAGE_TX, exp_np());
        end
        for (int i = 0; i < 8; i++) begin
            {crossover_force, crossover_enable, algo_swapped} = i[2:0];
            repeat (2) @(posedge ref_clk);
            #1 w = {15'h0000, i[2] | (i[1] & i[0])};
            check("xover", w, {15'h0000, crossover_state});
            rd(ANNP_OFS_PHY_STATUS, {1'h0, w[0], status_low_bits});
        end
        // second reset in mid-run brings back the defaults
        {crossover_force, crossover_enable, algo_swapped} = 3'h0;
        sys_rst = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'h0;
        shadow = 16'h2001;
        tog = 1'h0;
        check("reset word", 16'h0000, tx_link_code_word);
        check("reset pending", 16'h0000, {15'h0000, next_page_loaded});
        rd(ANNP_OFS_NEXT_PAGE_TX, 16'h2001);
        rd(ANNP_OFS_PHY_STATUS, {2'h0, status_low_bits});
        stop_test();
    end
endmodule : annp_next_page_regs_bench
bind annp_next_page_regs annp_chk annp_chk_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .base_page_sent(base_page_sent),
    .base_page_toggle(base_page_toggle),
    .next_page_sent(next_page_sent),
    .tx_link_code_word(tx_link_code_word),
    .next_page_loaded(next_page_loaded),
    .crossover_enable(crossover_enable),
    .crossover_force(crossover_force),
    .algo_swapped(algo_swapped),
    .crossover_state(crossover_state)
);
